/* hdl/bfag_cfg.svh */
// Constants for the boot flash access guard.
// Assumes word addresses into program flash, fuse and lock bits active low.
`ifndef BFAG_CFG_SVH
`define BFAG_CFG_SVH
`define BFAG_AW            15
`define BFAG_FLASH_WORDS   16'h4000
`define BFAG_HALT_START    15'h3800
`define BFAG_APP_RESET     15'h0000
`define BFAG_LOCK_RESET    6'h3F
`define BFAG_CMD_WINDOW    3'h4
`define BFAG_ERASE_NS      4000000
`define BFAG_CLK_MHZ       40
`define BFAG_ERASE_CYC     ((`BFAG_ERASE_NS * `BFAG_CLK_MHZ) / 1000)
`define BFAG_CNT_W         24
`define BFAG_REG_CTRL      4'h0
`define BFAG_REG_LOCK      4'h4
`define BFAG_REG_FUSE      4'h8
`define BFAG_REG_FETCH     4'hC
`define BFAG_CTRL_EN       0
`define BFAG_CTRL_ERASE    1
`define BFAG_CTRL_WRITE    2
`define BFAG_CTRL_LOCKSET  3
`define BFAG_CTRL_RDEN     4
`define BFAG_CTRL_BUSY     6
`define BFAG_LK_APP_WR     0
`define BFAG_LK_APP_RD     1
`define BFAG_LK_LDR_WR     2
`define BFAG_LK_LDR_RD     3
`endif

/* hdl/bfag_guard.sv */
// Boot flash access guard with Avalon-MM register slave.
// Assumes fuses and lock pins come from slow non-volatile logic, synchronised here.
// Operation
// - Store-program fetched from application section never starts programming.
// - Loader code may store-program any address, limited only by locks.
// - Loader boundary follows size fuses; each section has its own lock pair.
// - Concurrent-section programming leaves halting-section fetches allowed.
// - Halting-section programming stalls the core for the whole operation.
// - Concurrent or halting chosen by programmed address, not fetch address.
// - Loader section lies wholly inside halting section.
// - Busy flag reads one while concurrent section is blocked.
// - Reset vector is 0x0000 with fuse at 1, loader start with 0.
// - Core has no path to change fuses.
// - Locks only get programmed; only chip erase returns them to one.
// - General write lock does not block store-program.
// - General read/write lock does not block load or store program.
// - Application locks both one: no restriction on application section.
// - Application write lock zero refuses stores into application section.
// - Application read lock zero blocks loader reads of application; masks interrupts.
// - Loader locks both one: no restriction on loader section.
// - Loader write lock zero refuses stores into loader section.
// - Loader read lock zero blocks application reads of loader; masks interrupts.
// - Writing concurrent read enable clears busy and unblocks reads.
// - Lock-set command programs each lock whose data bit is zero.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "bfag_cfg.svh"
module bfag_guard
  import bfag_pkg::*;
#(
  parameter int          AW        = `BFAG_AW,
  parameter logic [23:0] ERASE_CYC = 24'(`BFAG_ERASE_CYC)
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [1:0]    loader_size_fuses,
  input  wire logic          reset_to_loader_fuse,
  input  wire logic [5:0]    lock_bits_in,
  input  wire logic          chip_erase,
  input  wire logic          ivec_in_loader,
  input  wire logic          store_program_instr,
  input  wire logic [AW-1:0] store_addr,
  input  wire logic [7:0]    store_data,
  input  wire logic [AW-1:0] pc_addr,
  input  wire logic          lpm_req,
  input  wire logic [AW-1:0] lpm_addr,
  output logic               lpm_allow,
  output logic               flash_prog_start,
  output logic               flash_prog_erase,
  output logic [AW-1:0]      flash_prog_addr,
  input  wire logic          flash_prog_done,
  output logic               core_stall,
  output logic               concurrent_section_busy,
  output logic               irq_mask,
  output logic [AW-1:0]      reset_vector,
  output logic [5:0]         lock_state
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]    sz_s1;
    logic [1:0]    sz_s2;
    logic          rst_s1;
    logic          rst_s2;
    logic [5:0]    lk_s1;
    logic [5:0]    lk_s2;
    logic          ce_s1;
    logic          ce_s2;
    logic          captured;
    logic [1:0]    fill;
    logic [1:0]    size;
    logic          rst_fuse;
    logic [5:0]    lock;
    logic [3:0]    cmd;
    logic [2:0]    win;
    bfag_state_e   st;
    logic          halt_op;
    logic          busy;
    logic [23:0]   cnt;
    logic          start;
    logic          erase;
    logic [AW-1:0] paddr;
    logic          lpm_ok;
    logic [31:0]   rdata;
    logic          ack;
  } bfag_state_s;

  bfag_state_s s_q;
  bfag_state_s s_d;

  logic [AW-1:0] loader_start;
  logic [AW-1:0] halt_start;
  logic          store_in_ldr;
  logic          store_in_halt;
  logic          pc_in_ldr;
  logic          pc_in_halt;
  logic          lpm_in_ldr;
  logic          lpm_in_halt;
  logic          allow_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Section decode
  always_comb begin
    // Loader size: 256, 512, 1024 or 2048 words below the top
    case (s_q.size)
      2'h3:    loader_start = AW'(16'h4000 - 16'h0100);
      2'h2:    loader_start = AW'(16'h4000 - 16'h0200);
      2'h1:    loader_start = AW'(16'h4000 - 16'h0400);
      default: loader_start = AW'(16'h4000 - 16'h0800);
    endcase
  end
  assign halt_start = AW'(`BFAG_HALT_START);

  bfag_section_decode #(.AW(AW)) u_dec_store (
    .addr         (store_addr),
    .loader_start (loader_start),
    .halt_start   (halt_start),
    .in_loader    (store_in_ldr),
    .in_halting   (store_in_halt)
  );
  bfag_section_decode #(.AW(AW)) u_dec_pc (
    .addr         (pc_addr),
    .loader_start (loader_start),
    .halt_start   (halt_start),
    .in_loader    (pc_in_ldr),
    .in_halting   (pc_in_halt)
  );
  bfag_section_decode #(.AW(AW)) u_dec_lpm (
    .addr         (lpm_addr),
    .loader_start (loader_start),
    .halt_start   (halt_start),
    .in_loader    (lpm_in_ldr),
    .in_halting   (lpm_in_halt)
  );

  // Write permission per target section; general lock modes play no part
  assign allow_wr = store_in_ldr ? s_q.lock[`BFAG_LK_LDR_WR]
                               : s_q.lock[`BFAG_LK_APP_WR];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    s_d.ack   = 1'b0;
    // Pin synchronisers
    s_d.sz_s1  = loader_size_fuses;
    s_d.sz_s2  = s_q.sz_s1;
    s_d.rst_s1 = reset_to_loader_fuse;
    s_d.rst_s2 = s_q.rst_s1;
    s_d.lk_s1  = lock_bits_in;
    s_d.lk_s2  = s_q.lk_s1;
    s_d.ce_s1  = chip_erase;
    s_d.ce_s2  = s_q.ce_s1;
    // Capture once the synchronisers hold pin values; no bus path writes fuses
    s_d.fill = {s_q.fill[0], 1'b1};
    if (!s_q.captured) begin
      if (s_q.fill[1]) begin
        s_d.captured = 1'b1;
        s_d.size     = s_q.sz_s2;
        s_d.rst_fuse = s_q.rst_s2;
        s_d.lock     = s_q.lk_s2;
      end
    end else if (s_q.ce_s2) begin
      s_d.lock = 6'(`BFAG_LOCK_RESET);
    end
    // Command window
    if (s_q.win != 3'h0) begin
      s_d.win = s_q.win - 3'h1;
    end
    if (s_q.st == BFAG_ARMED && s_q.win == 3'h0) begin
      s_d.st  = BFAG_IDLE;
      s_d.cmd = 4'h0;
    end
    // Register slave, one wait state
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_read) begin
        case (avs_address)
          `BFAG_REG_CTRL:  s_d.rdata = {25'h0, s_q.busy, 2'h0, s_q.cmd};
          `BFAG_REG_LOCK:  s_d.rdata = {26'h0, s_q.lock};
          `BFAG_REG_FUSE:  s_d.rdata = {29'h0, s_q.rst_fuse, s_q.size};
          `BFAG_REG_FETCH: s_d.rdata = {17'h0, 15'(loader_start)};
          default:         s_d.rdata = 32'h0;
        endcase
      end
    end
    // Writes land on the edge where waitrequest is sampled low
    if (avs_write && s_q.ack && avs_address == `BFAG_REG_CTRL && avs_byteenable[0] && s_q.st != BFAG_PROG) begin
      if (avs_writedata[`BFAG_CTRL_RDEN] && avs_writedata[`BFAG_CTRL_EN]) begin
        s_d.busy = 1'b0;
      end else if (avs_writedata[`BFAG_CTRL_EN]) begin
        s_d.cmd = avs_writedata[3:0];
        s_d.st  = BFAG_ARMED;
        s_d.win = 3'(`BFAG_CMD_WINDOW);
      end
    end
    // Store-program trigger
    case (s_q.st)
      BFAG_IDLE: begin
      end
      BFAG_ARMED: begin
        if (store_program_instr && s_q.win != 3'h0) begin
          s_d.st  = BFAG_IDLE;
          s_d.cmd = 4'h0;
          if (pc_in_ldr) begin
            if (s_q.cmd[`BFAG_CTRL_LOCKSET]) begin
              s_d.lock = s_q.lock & store_data[5:0];
            end else if ((s_q.cmd[`BFAG_CTRL_ERASE] || s_q.cmd[`BFAG_CTRL_WRITE]) && allow_wr) begin
              s_d.st      = BFAG_PROG;
              s_d.start   = 1'b1;
              s_d.erase   = s_q.cmd[`BFAG_CTRL_ERASE];
              s_d.paddr   = store_addr;
              s_d.halt_op = store_in_halt;
              s_d.busy    = !store_in_halt | s_d.busy;
              s_d.cnt     = ERASE_CYC;
            end
          end
        end
      end
      BFAG_PROG: begin
        if (s_q.cnt != 24'h0) begin
          s_d.cnt = s_q.cnt - 24'h1;
        end
        if (flash_prog_done || s_q.cnt == 24'h0) begin
          s_d.st = BFAG_DONE;
        end
      end
      BFAG_DONE: begin
        s_d.st      = BFAG_IDLE;
        s_d.halt_op = 1'b0;
      end
      default: s_d.st = BFAG_IDLE;
    endcase
    // Load-program permission
    if (lpm_in_ldr) begin
      s_d.lpm_ok = pc_in_ldr | s_q.lock[`BFAG_LK_LDR_RD];
    end else begin
      s_d.lpm_ok = (!pc_in_ldr | s_q.lock[`BFAG_LK_APP_RD])
                   & !(s_q.busy && !lpm_in_halt);
    end
    if (!lpm_req) begin
      s_d.lpm_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.size     <= 2'h0;
      s_q.rst_fuse <= 1'b1;
      s_q.lock     <= 6'(`BFAG_LOCK_RESET);
      s_q.st       <= BFAG_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata            = s_q.rdata;
  assign avs_waitrequest         = (avs_read || avs_write) && !s_q.ack;
  assign flash_prog_start        = s_q.start;
  assign flash_prog_erase        = s_q.erase;
  assign flash_prog_addr         = s_q.paddr;
  assign core_stall              = s_q.st == BFAG_PROG && s_q.halt_op;
  assign concurrent_section_busy = s_q.busy;
  assign lpm_allow               = s_q.lpm_ok;
  assign lock_state              = s_q.lock;
  assign reset_vector            = s_q.rst_fuse ? AW'(`BFAG_APP_RESET) : loader_start;
  assign irq_mask = ( ivec_in_loader && !pc_in_ldr && !s_q.lock[`BFAG_LK_APP_RD]) ||
                    (!ivec_in_loader &&  pc_in_ldr && !s_q.lock[`BFAG_LK_LDR_RD]);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_stall_halting: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(s_q.start) && s_q.halt_op |-> core_stall)
    else $error("halting program did not stall");
  chk_concurrent_nostall: assert property (@(posedge clk) disable iff (!arst_n)
    s_q.start && !s_q.halt_op |-> !core_stall && concurrent_section_busy)
    else $error("concurrent program stalled or not busy");
  chk_app_no_start: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && store_program_instr && !pc_in_ldr |=> !flash_prog_start)
    else $error("application code started programming");
  chk_app_wr_lock: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !store_in_ldr && !s_q.lock[`BFAG_LK_APP_WR] |=> !flash_prog_start)
    else $error("locked application write started");
  chk_ldr_wr_lock: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && store_in_ldr && !s_q.lock[`BFAG_LK_LDR_WR] |=> !flash_prog_start)
    else $error("locked loader write started");
  chk_lock_no_clear: assert property (@(posedge clk) disable iff (!arst_n)
    s_q.captured && !s_q.ce_s2 |=> (lock_state & ~$past(lock_state)) == 6'h0)
    else $error("lock bit returned to one without erase");
  chk_busy_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && s_q.ack && avs_write && avs_address == 4'h0 && avs_writedata[4] && avs_writedata[0]
      && s_q.st != BFAG_PROG && s_q.st != BFAG_ARMED |=> !concurrent_section_busy)
    else $error("busy not cleared by read enable");
  chk_reset_vector: assert property (@(posedge clk) disable iff (!arst_n)
    s_q.rst_fuse |-> reset_vector == 15'h0000)
    else $error("reset vector wrong");
  chk_ldr_read_lock: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && lpm_req && lpm_in_ldr && !pc_in_ldr && !s_q.lock[`BFAG_LK_LDR_RD] |=> !lpm_allow)
    else $error("locked loader read allowed");
  chk_window_expiry: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && s_q.st == BFAG_ARMED && s_q.win == 3'h0 |=> !flash_prog_start)
    else $error("store accepted after command window");
  chk_refused_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && store_program_instr && s_q.st == BFAG_ARMED && !allow_wr |=> !flash_prog_start && !core_stall)
    else $error("refused store started or stalled");
  chk_stall_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && core_stall && !flash_prog_done && s_q.cnt != 24'h0 |=> core_stall)
    else $error("stall dropped before operation end");
  chk_lpm_busy_block: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && lpm_req && concurrent_section_busy && !lpm_in_halt |=> !lpm_allow)
    else $error("concurrent read allowed while busy");
  chk_fuse_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_q.captured |=> $stable(s_q.size) && $stable(s_q.rst_fuse))
    else $error("captured fuses changed");
  chk_loader_vector: assert property (@(posedge clk) disable iff (!arst_n)
    !s_q.rst_fuse |-> reset_vector == loader_start)
    else $error("loader reset vector wrong");
  cov_halting_prog: cover property (@(posedge clk) disable iff (!arst_n) core_stall ##1 !core_stall);
  cov_concurrent_prog: cover property (@(posedge clk) disable iff (!arst_n) $rose(concurrent_section_busy));
  cov_lock_set: cover property (@(posedge clk) disable iff (!arst_n) s_q.captured && $changed(lock_state));
  cov_window_expiry: cover property (@(posedge clk) disable iff (!arst_n) s_q.st == BFAG_ARMED && s_q.win == 3'h0);
  cov_lock_erase: cover property (@(posedge clk) disable iff (!arst_n) s_q.ce_s2 && lock_state != 6'h3F);
endmodule

/* hdl/bfag_pkg.sv */
// Types for the boot flash access guard.
// Assumes bfag_cfg.svh is reachable on the include path.
package bfag_pkg;
  typedef enum logic [1:0] {
    BFAG_IDLE  = 2'h0,
    BFAG_ARMED = 2'h1,
    BFAG_PROG  = 2'h3,
    BFAG_DONE  = 2'h2
  } bfag_state_e;
  typedef logic [14:0] bfag_addr_t;
endpackage

/* hdl/bfag_section_decode.sv */
// Section decode of one flash word address.
// Assumes the boundary inputs are stable between resets.
`timescale 1ns/100ps
module bfag_section_decode
  import bfag_pkg::*;
#(
  parameter int AW = 15
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] loader_start,
  input  wire logic [AW-1:0] halt_start,
  output logic               in_loader,
  output logic               in_halting
);
  // Loader section from boundary to top; halting section is the top fixed part
  assign in_loader  = (addr >= loader_start);
  assign in_halting = (addr >= halt_start);
endmodule

/* verification/bfag_flash_model.sv */
// Flash array stand-in: answers each programming start with a one-cycle done pulse.
// Assumes start is a one-cycle pulse and dly is held steady during an operation.
`timescale 1ns/100ps
module bfag_flash_model
  import bfag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] dly,
  input  wire logic       flash_prog_start,
  output logic            flash_prog_done
);
  logic [7:0] cnt_q;
  // Counts down the array busy time; dly sets a prompt or a slow answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q           <= 8'h00;
      flash_prog_done <= 1'b0;
    end else begin
      flash_prog_done <= (cnt_q == 8'h01);
      if (flash_prog_start) begin
        cnt_q <= dly;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the boot flash access guard.
// Assumes the guard's hand-over timing and a flash model answering start with done.
`timescale 1ns/100ps
module tb;
  import bfag_pkg::*;
  logic clk = 0, arst_n = 0, store_pulse = 0, lpm_req = 0, ivec = 0, rst_fuse = 1, cerase = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest, lpm_allow, start, erase, done, stall, busy, irq_mask;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
  logic [1:0] fuses = 2'h3;
  logic [5:0] lock_state;
  logic [7:0] store_data = 8'h00, dly = 8'h0C;
  logic [14:0] store_addr = 15'h0, pc = 15'h0, lpm_addr = 15'h0, prog_addr, reset_vector;
  int fail_count = 0, n_tests = 0;
  localparam logic [14:0] LDR = 15'h3F10, APP = 15'h0100;
  always #12.5 clk = ~clk;
  bfag_guard #(.ERASE_CYC(24'h14)) i_bfag_guard (.clk(clk), .arst_n(arst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .loader_size_fuses(fuses), .reset_to_loader_fuse(rst_fuse), .lock_bits_in(6'h3F), .chip_erase(cerase),
    .ivec_in_loader(ivec), .store_program_instr(store_pulse), .store_addr(store_addr), .store_data(store_data),
    .pc_addr(pc), .lpm_req(lpm_req), .lpm_addr(lpm_addr), .lpm_allow(lpm_allow), .flash_prog_start(start),
    .flash_prog_erase(erase), .flash_prog_addr(prog_addr), .flash_prog_done(done), .core_stall(stall),
    .concurrent_section_busy(busy), .irq_mask(irq_mask), .reset_vector(reset_vector), .lock_state(lock_state));
  bfag_flash_model i_bfag_flash_model (.clk(clk), .arst_n(arst_n), .dly(dly), .flash_prog_start(start),
    .flash_prog_done(done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic do_store(input logic [14:0] p, input logic [7:0] c, input logic [14:0] t,
                          input logic [7:0] d, input logic e);
    logic seen;
    pc <= p;
    bus(1'b1, 4'h0, {24'h0, c}, r);
    store_addr <= t;
    store_data <= d;
    store_pulse <= 1'b1;
    @(posedge clk);
    store_pulse <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk);
      seen = seen | start;
    end
    if (e !== 1'bx) chk("prog_start", seen, e);
  endtask
  task automatic lpm(input logic [14:0] p, input logic [14:0] a, input logic e);
    pc <= p;
    lpm_addr <= a;
    lpm_req <= 1'b1;
    @(posedge clk);
    lpm_req <= 1'b0;
    @(posedge clk);
    chk("lpm_allow", lpm_allow, e);
  endtask
  task automatic wait_sig(input int which, input logic v);
    int n;
    n = 0;
    while (((which == 0) ? done : lock_state[0]) !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    do_reset();
    chk("reset_vector", reset_vector, 15'h0000);
    chk("lock_state", lock_state, 6'h3F);
    bus(1'b0, 4'h2, 32'h0, r);
    chk("unmapped", r, 32'h0);
    lpm(LDR, APP, 1'b1);
    lpm(APP, 15'h3F80, 1'b1);
    do_store(APP, 8'h05, APP, 8'h00, 1'b0);
    do_store(LDR, 8'h09, 15'h0001, 8'h0F, 1'bx);
    chk("lock_state", lock_state, 6'h0F);
    bus(1'b1, 4'h0, 32'h05, r);
    repeat (4) @(posedge clk);
    store_addr <= APP;
    store_pulse <= 1'b1;
    @(posedge clk);
    store_pulse <= 1'b0;
    @(posedge clk);
    chk("late_start", start, 1'b0);
    bus(1'b0, 4'h0, 32'h0, r);
    chk("ctrl", r, 32'h0);
    do_store(LDR, 8'h05, APP, 8'h00, 1'b1);
    chk("busy", busy, 1'b1);
    chk("stall", stall, 1'b0);
    lpm(LDR, 15'h3F80, 1'b1);
    lpm(LDR, APP, 1'b0);
    wait_sig(0, 1'b1);
    repeat (2) @(posedge clk);
    chk("busy", busy, 1'b1);
    bus(1'b0, 4'h0, 32'h0, r);
    chk("ctrl", r, 32'h40);
    bus(1'b1, 4'h0, 32'h11, r);
    @(posedge clk);
    chk("busy", busy, 1'b0);
    dly <= 8'h0C;
    do_store(LDR, 8'h03, 15'h3900, 8'h00, 1'b1);
    chk("stall", stall, 1'b1);
    chk("busy", busy, 1'b0);
    wait_sig(0, 1'b1);
    repeat (2) @(posedge clk);
    chk("stall", stall, 1'b0);
    do_store(LDR, 8'h09, 15'h0001, 8'hC0, 1'bx);
    chk("lock_state", lock_state, 6'h00);
    do_store(LDR, 8'h05, APP, 8'h00, 1'b0);
    chk("busy", busy, 1'b0);
    do_store(LDR, 8'h05, 15'h3F40, 8'h00, 1'b0);
    chk("stall", stall, 1'b0);
    lpm(LDR, APP, 1'b0);
    lpm(APP, 15'h3F80, 1'b0);
    ivec <= 1'b1;
    pc <= APP;
    @(posedge clk);
    @(posedge clk);
    chk("irq_mask", irq_mask, 1'b1);
    ivec <= 1'b0;
    pc <= LDR;
    @(posedge clk);
    @(posedge clk);
    chk("irq_mask", irq_mask, 1'b1);
    do_store(LDR, 8'h09, 15'h0001, 8'hFF, 1'bx);
    chk("lock_state", lock_state, 6'h00);
    cerase <= 1'b1;
    repeat (4) @(posedge clk);
    cerase <= 1'b0;
    wait_sig(1, 1'b1);
    chk("lock_state", lock_state, 6'h3F);
    for (int f = 0; f < 4; f++) begin
      fuses <= f[1:0];
      rst_fuse <= 1'b0;
      do_reset();
      chk("reset_vector", reset_vector, 32'h4000 - (32'h100 << (3 - f)));
      bus(1'b0, 4'hC, 32'h0, r);
      chk("loader_start", r, 32'h4000 - (32'h100 << (3 - f)));
    end
    rst_fuse <= 1'b1;
    repeat (6) @(posedge clk);
    chk("reset_vector", reset_vector, 15'h3F00);
    summarize();
  end
endmodule
